// ### core/spi_regmap_pkg.sv
// Package with the register map, field positions and reset values.
package spi_regmap_pkg;

  // Address and data widths of the serial port.
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int HDR_BITS = 16;
  localparam int POS_W = 24;

  // Byte addresses of the registers.
  localparam logic [14:0] OFS_PORT_CONFIG   = 15'h0000;
  localparam logic [14:0] OFS_CLASS         = 15'h0003;
  localparam logic [14:0] OFS_FAMILY_LO     = 15'h0004;
  localparam logic [14:0] OFS_FAMILY_HI     = 15'h0005;
  localparam logic [14:0] OFS_MAKER_LO      = 15'h000c;
  localparam logic [14:0] OFS_MAKER_HI      = 15'h000d;
  localparam logic [14:0] OFS_USER_CONFIG   = 15'h0010;
  localparam logic [14:0] OFS_REF_CTRL0     = 15'h0029;
  localparam logic [14:0] OFS_REF_CTRL1     = 15'h002a;
  localparam logic [14:0] OFS_POS_LO        = 15'h002c;
  localparam logic [14:0] OFS_POS_MID       = 15'h002d;
  localparam logic [14:0] OFS_POS_HI        = 15'h002e;

  // Address step of a streaming access.
  localparam logic [14:0] ADDR_STEP = 15'h0001;

  // Field positions in the port configuration register.
  localparam int SOFT_RESET_BIT = 7;
  localparam int ASCEND_BIT     = 5;
  localparam int SDO_ACTIVE_BIT = 4;

  // Field positions in the user configuration register.
  localparam int ADDR_HOLD_BIT = 0;

  // Field positions in the first reference clock control register.
  localparam int PROC_EN_BIT = 6;
  localparam int RECV_EN_BIT = 5;
  localparam int FINE_WIN_BIT = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;

  // Field positions in the second reference clock control register.
  localparam int TSTAMP_BIT = 3;
  localparam int DEV_LVPECL_BIT = 2;
  localparam int REF_LVPECL_BIT = 1;
  localparam int REF_INV_BIT = 0;

  // Reset values.
  localparam logic [7:0] PORT_CONFIG_RST = 8'h30;
  localparam logic [3:0] CLASS_HI_RST    = 4'h0;
  localparam logic [7:0] USER_CONFIG_RST = 8'h00;
  localparam logic [7:0] REF_CTRL0_RST   = 8'h00;
  localparam logic [7:0] REF_CTRL1_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // Writable bits of the port configuration register.
  localparam logic [7:0] PORT_CONFIG_WMASK = 8'h6f;

  // Least serial clock half period, in system clock cycles.
  localparam int SCLK_MIN_HALF_CYC = 3;

endpackage

// ### core/spi_access_if.sv
// Interface between the serial shifter and the register bank.
interface spi_access_if;

  // Header and data events from the shifter, read data back.
  logic        hdrDone;
  logic        rnw;
  logic [14:0] addr;
  logic        byteDone;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport shifter (
    output hdrDone,
    output rnw,
    output addr,
    output byteDone,
    output wdata,
    input  rdata
  );

  modport bank (
    input  hdrDone,
    input  rnw,
    input  addr,
    input  byteDone,
    input  wdata,
    output rdata
  );

endinterface

// ### core/spi_serial_port.sv
// Serial port shifter: header capture, byte assembly and read shifting.
module spi_serial_port (
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Serial pins.
  input  wire logic   sclk,
  input  wire logic   csN,
  input  wire logic   sdi,
  output logic        sdo,
  // Register bank side.
  spi_access_if.shifter acc
);

  logic        sclkPrev_r;
  logic        inHdr_r;
  logic [3:0]  bitCnt_r;
  logic [15:0] shiftIn_r;
  logic [7:0]  txShift_r;
  logic        rise;
  logic        fall;

  // Edges of the serial clock seen only inside a frame.
  assign rise = sclk & ~sclkPrev_r & ~csN;
  assign fall = ~sclk & sclkPrev_r & ~csN;

  // Previous serial clock level.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclk;
    end
  end

  // Bit counting and input shifting; a high select restarts the header.
  always_ff @(posedge clk) begin
    if (!rst_n || csN) begin
      inHdr_r   <= 1'b1;
      bitCnt_r  <= 4'h0;
      shiftIn_r <= 16'h0000;
    end else if (rise) begin
      shiftIn_r <= {shiftIn_r[14:0], sdi};
      if (inHdr_r && bitCnt_r == 4'hf) begin
        inHdr_r  <= 1'b0;
        bitCnt_r <= 4'h0;
      end else if (!inHdr_r && bitCnt_r == 4'h7) begin
        bitCnt_r <= 4'h0;
      end else begin
        bitCnt_r <= bitCnt_r + 4'h1;
      end
    end
  end

  // Header and byte events, one cycle after the completing edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc.hdrDone  <= 1'b0;
      acc.byteDone <= 1'b0;
      acc.rnw      <= 1'b0;
      acc.addr     <= 15'h0000;
      acc.wdata    <= 8'h00;
    end else begin
      acc.hdrDone  <= rise & inHdr_r & (bitCnt_r == 4'hf);
      acc.byteDone <= rise & ~inHdr_r & (bitCnt_r == 4'h7);
      if (rise && inHdr_r && bitCnt_r == 4'hf) begin
        acc.rnw  <= shiftIn_r[14];
        acc.addr <= {shiftIn_r[13:0], sdi};
      end
      if (rise && !inHdr_r && bitCnt_r == 4'h7) begin
        acc.wdata <= {shiftIn_r[6:0], sdi};
      end
    end
  end

  // Read data leaves most significant bit first on falling edges.
  always_ff @(posedge clk) begin
    if (!rst_n || csN) begin
      txShift_r <= 8'h00;
      sdo       <= 1'b0;
    end else if (fall && !inHdr_r && acc.rnw) begin
      if (bitCnt_r == 4'h0) begin
        sdo       <= acc.rdata[7];
        txShift_r <= {acc.rdata[6:0], 1'b0};
      end else begin
        sdo       <= txShift_r[7];
        txShift_r <= {txShift_r[6:0], 1'b0};
      end
    end
  end

endmodule

// ### core/position_snapshot.sv
// Holds the capture position steady while a serial frame is open.
module position_snapshot #(
  parameter int POS_W = spi_regmap_pkg::POS_W
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Freeze control and live position.
  input  wire logic             freeze,
  input  wire logic [POS_W-1:0] posIn,
  // Held position.
  output logic      [POS_W-1:0] posHeld
);

  // Track the live value outside frames so all bytes read coherently.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      posHeld <= '0;
    end else if (!freeze) begin
      posHeld <= posIn;
    end
  end

endmodule

// ### core/id_and_sync_clock_config_regs.sv
// Identification and reference clock configuration register bank.
module id_and_sync_clock_config_regs #(
  // Identification codes; the values are arbitrary.
  parameter logic [3:0]  DEVICE_CLASS = 4'h5,
  parameter logic [15:0] FAMILY_CODE  = 16'h1234,
  parameter logic [15:0] MAKER_CODE   = 16'habcd
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial configuration port.
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        sdi,
  output logic             sdo,
  // Capture position from the reference windowing logic.
  input  wire logic [23:0] refCapturePos,
  // Reference controls.
  output logic             refReceiverEnable,
  output logic             refProcessorEnable,
  output logic             refFineWindow,
  output logic [3:0]       refDelaySelect,
  // Second clock control bits.
  output logic             refTimestampEnable,
  output logic             devClkLvpeclEnable,
  output logic             refLvpeclEnable,
  output logic             refInvert
);

  spi_access_if acc ();

  logic [7:0]  portCfg_r;
  logic [3:0]  classHi_r;
  logic [7:0]  userCfg_r;
  logic [7:0]  refCtrl0_r;
  logic [7:0]  refCtrl1_r;
  logic        softRst_r;
  logic [14:0] curAddr_r;
  logic [23:0] posHeld;
  logic        regRst;
  logic        wrEn;
  logic        ascend;
  logic        addrHold;
  logic [7:0]  rdByte;

  // Serial shifter.
  spi_serial_port u_port (
    .clk   (clk),
    .rst_n (rst_n),
    .sclk  (sclk),
    .csN   (csN),
    .sdi   (sdi),
    .sdo   (sdo),
    .acc   (acc)
  );

  // Capture position held steady during frames.
  position_snapshot #(
    .POS_W (spi_regmap_pkg::POS_W)
  ) u_snap (
    .clk     (clk),
    .rst_n   (rst_n),
    .freeze  (~csN),
    .posIn   (refCapturePos),
    .posHeld (posHeld)
  );

  // Register reset covers pin reset and the self-clearing soft reset.
  assign regRst   = ~rst_n | softRst_r;
  assign wrEn     = acc.byteDone & ~acc.rnw;
  assign ascend   = portCfg_r[spi_regmap_pkg::ASCEND_BIT];
  assign addrHold = userCfg_r[spi_regmap_pkg::ADDR_HOLD_BIT];

  // Streaming address: loaded by the header, stepped after each byte unless the address hold bit is set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      curAddr_r <= 15'h0000;
    end else if (acc.hdrDone) begin
      curAddr_r <= acc.addr;
    end else if (acc.byteDone && !addrHold) begin
      if (ascend) begin
        curAddr_r <= curAddr_r + spi_regmap_pkg::ADDR_STEP;
      end else begin
        curAddr_r <= curAddr_r - spi_regmap_pkg::ADDR_STEP;
      end
    end
  end

  // Soft reset request lasts one cycle and then clears itself.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      softRst_r <= 1'b0;
    end else begin
      softRst_r <= wrEn &&
                   curAddr_r == spi_regmap_pkg::OFS_PORT_CONFIG &&
                   acc.wdata[spi_regmap_pkg::SOFT_RESET_BIT];
    end
  end

  // Port configuration; the soft reset and active bits are not stored.
  always_ff @(posedge clk) begin
    if (regRst) begin
      portCfg_r <= spi_regmap_pkg::PORT_CONFIG_RST;
    end else if (wrEn && curAddr_r == spi_regmap_pkg::OFS_PORT_CONFIG) begin
      portCfg_r <= (acc.wdata & spi_regmap_pkg::PORT_CONFIG_WMASK) |
                   (portCfg_r & ~spi_regmap_pkg::PORT_CONFIG_WMASK);
    end
  end

  // Reserved upper nibble of the class register keeps what is written.
  always_ff @(posedge clk) begin
    if (regRst) begin
      classHi_r <= spi_regmap_pkg::CLASS_HI_RST;
    end else if (wrEn && curAddr_r == spi_regmap_pkg::OFS_CLASS) begin
      classHi_r <= acc.wdata[7:4];
    end
  end

  // User configuration with the address hold bit.
  always_ff @(posedge clk) begin
    if (regRst) begin
      userCfg_r <= spi_regmap_pkg::USER_CONFIG_RST;
    end else if (wrEn && curAddr_r == spi_regmap_pkg::OFS_USER_CONFIG) begin
      userCfg_r <= acc.wdata;
    end
  end

  // First reference clock control register.
  always_ff @(posedge clk) begin
    if (regRst) begin
      refCtrl0_r <= spi_regmap_pkg::REF_CTRL0_RST;
    end else if (wrEn && curAddr_r == spi_regmap_pkg::OFS_REF_CTRL0) begin
      refCtrl0_r <= acc.wdata;
    end
  end

  // Second reference clock control register.
  always_ff @(posedge clk) begin
    if (regRst) begin
      refCtrl1_r <= spi_regmap_pkg::REF_CTRL1_RST;
    end else if (wrEn && curAddr_r == spi_regmap_pkg::OFS_REF_CTRL1) begin
      refCtrl1_r <= acc.wdata;
    end
  end

  // Control outputs straight from the stored bits.
  assign refReceiverEnable =
    refCtrl0_r[spi_regmap_pkg::RECV_EN_BIT];
  assign refProcessorEnable =
    refCtrl0_r[spi_regmap_pkg::PROC_EN_BIT];
  assign refFineWindow =
    refCtrl0_r[spi_regmap_pkg::FINE_WIN_BIT];
  assign refDelaySelect =
    refCtrl0_r[spi_regmap_pkg::SEL_MSB:spi_regmap_pkg::SEL_LSB];
  assign refTimestampEnable = refCtrl1_r[spi_regmap_pkg::TSTAMP_BIT];
  assign devClkLvpeclEnable = refCtrl1_r[spi_regmap_pkg::DEV_LVPECL_BIT];
  assign refLvpeclEnable    = refCtrl1_r[spi_regmap_pkg::REF_LVPECL_BIT];
  assign refInvert          = refCtrl1_r[spi_regmap_pkg::REF_INV_BIT];

  // Read data for the current streaming address.
  always_comb begin
    rdByte = spi_regmap_pkg::UNMAPPED_READ;
    unique case (curAddr_r)
      spi_regmap_pkg::OFS_PORT_CONFIG: begin
        rdByte = portCfg_r;
        rdByte[spi_regmap_pkg::SOFT_RESET_BIT] = 1'b0;
        rdByte[spi_regmap_pkg::SDO_ACTIVE_BIT] = 1'b1;
      end
      spi_regmap_pkg::OFS_CLASS: begin
        rdByte = {classHi_r, DEVICE_CLASS};
      end
      spi_regmap_pkg::OFS_FAMILY_LO:   rdByte = FAMILY_CODE[7:0];
      spi_regmap_pkg::OFS_FAMILY_HI:   rdByte = FAMILY_CODE[15:8];
      spi_regmap_pkg::OFS_MAKER_LO:    rdByte = MAKER_CODE[7:0];
      spi_regmap_pkg::OFS_MAKER_HI:    rdByte = MAKER_CODE[15:8];
      spi_regmap_pkg::OFS_USER_CONFIG: rdByte = userCfg_r;
      spi_regmap_pkg::OFS_REF_CTRL0:   rdByte = refCtrl0_r;
      spi_regmap_pkg::OFS_REF_CTRL1:   rdByte = refCtrl1_r;
      spi_regmap_pkg::OFS_POS_LO:      rdByte = posHeld[7:0];
      spi_regmap_pkg::OFS_POS_MID:     rdByte = posHeld[15:8];
      spi_regmap_pkg::OFS_POS_HI:      rdByte = posHeld[23:16];
      default:                         rdByte = spi_regmap_pkg::UNMAPPED_READ;
    endcase
  end

  // Family and maker bytes have no storage, so writes there change nothing; the class upper nibble is stored.
  assign acc.rdata = rdByte;

endmodule

// ### bench/id_regs_chk.sv
// Checker watching the register bank's top-level ports.
module id_regs_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Serial pins.
  input wire logic        sclk,
  input wire logic        csN,
  input wire logic        sdi,
  input wire logic        sdo,
  // Position and controls.
  input wire logic [23:0] refCapturePos,
  input wire logic        refReceiverEnable,
  input wire logic        refProcessorEnable,
  input wire logic        refFineWindow,
  input wire logic [3:0]  refDelaySelect,
  input wire logic        refTimestampEnable,
  input wire logic        devClkLvpeclEnable,
  input wire logic        refLvpeclEnable,
  input wire logic        refInvert
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclkPrev_r;
  logic [3:0] sinceRise_r;
  logic [4:0] bitCnt_r;
  logic       readFrame_r;
  logic       rise;
  logic [6:0] ctl0;
  logic [3:0] ctl1;

  // Control outputs gathered in register bit order.
  assign ctl0 = {refProcessorEnable, refReceiverEnable, refFineWindow,
                 refDelaySelect};
  assign ctl1 = {refTimestampEnable, devClkLvpeclEnable, refLvpeclEnable,
                 refInvert};
  assign rise = sclk & ~sclkPrev_r & ~csN;

  // Counts cycles since the last serial rise, saturating at 15.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkPrev_r  <= 1'b0;
      sinceRise_r <= 4'hf;
    end else begin
      sclkPrev_r  <= sclk;
      sinceRise_r <= rise ? 4'h0 : sinceRise_r + {3'h0, sinceRise_r != 4'hf};
    end
  end

  // Counts frame bits and keeps the direction bit of the header.
  always_ff @(posedge clk) begin
    if (!rst_n || csN) begin
      bitCnt_r    <= 5'h00;
      readFrame_r <= 1'b0;
    end else if (rise) begin
      bitCnt_r    <= bitCnt_r + {4'h0, bitCnt_r != 5'h11};
      readFrame_r <= (bitCnt_r == 5'h00) ? sdi : readFrame_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_clears:
  assert property ($rose(rst_n) |-> ctl0 == 7'h00 && ctl1 == 4'h0)
    else $error("control outputs not cleared by reset");
  chk_ctl_idle:
  assert property (csN [*5] |-> $stable(ctl0) && $stable(ctl1))
    else $error("control outputs moved outside a frame");
  chk_ctl_after_byte:
  assert property ($past(rst_n) && !$stable(ctl0) |-> sinceRise_r <= 4'h4)
    else $error("control outputs moved away from a byte end");
  chk_ctl_read_frame:
  assert property (!csN && readFrame_r |-> $stable(ctl0) && $stable(ctl1))
    else $error("control outputs moved in a read frame");
  chk_sdo_idle_low:
  assert property (csN && $past(csN) |-> !sdo)
    else $error("sdo not low outside a frame");
  chk_sdo_after_fall:
  assert property ($changed(sdo) |-> $past(csN) || !$past(sclk))
    else $error("sdo changed without a serial fall");
  chk_sdo_header_quiet:
  assert property (!csN && !(readFrame_r && bitCnt_r >= 5'h10) |-> !sdo)
    else $error("sdo driven outside read data");
  chk_sdo_read_only:
  assert property ($changed(sdo) && !$past(csN) |->
                   readFrame_r && bitCnt_r >= 5'h10)
    else $error("sdo changed outside a read data phase");
endmodule

// ### bench/spi_host_model.sv
// Serial host model that frames register reads and writes.
module spi_host_model (
  // Clock.
  input wire logic        clk,
  // Serial pins.
  output logic            sclk,
  output logic            csN,
  output logic            sdi,
  input wire logic        sdo,
  // Received read bytes.
  output logic [7:0]      rxByte,
  output logic            rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  int halfCyc = 4;

  // Keeps the serial clock still and the frame closed when idle.
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    rxByte = 8'h00;
    rxValid = 1'b0;
  end

  // Sends one bit and samples sdo as sclk rises.
  task automatic shift(input logic b, output logic s);
    sclk = 1'b0;
    sdi = b;
    repeat (halfCyc) @(negedge clk);
    s = sdo;
    sclk = 1'b1;
    repeat (halfCyc) @(negedge clk);
  endtask

  // Runs one frame: header, then n bytes, pulsing rxValid per read byte.
  task automatic frame(input logic rd, input logic [14:0] a, input int n,
                       input logic [7:0] wd [4]);
    logic        s;
    logic [15:0] h;
    h = {rd, a};
    csN = 1'b0;
    for (int i = 15; i >= 0; i--)
      shift(h[i], s);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        shift(wd[k][i], s);
        rxByte[i] = s;
      end
      rxValid = rd;
      @(negedge clk);
      rxValid = 1'b0;
    end
    sclk = 1'b0;
    repeat (halfCyc) @(negedge clk);
    csN = 1'b1;
    sdi = ~sdi;
    repeat (halfCyc) @(negedge clk);
  endtask
endmodule

// ### bench/tb_id_and_sync_clock_config_regs.sv
// Self-checking bench for the identification and clock control registers.
module tb_id_and_sync_clock_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // Identification codes; the values are arbitrary.
  localparam logic [3:0]  CLS = 4'h9;
  localparam logic [15:0] FAM = 16'h5a1c;
  localparam logic [15:0] MKR = 16'h3e07;
  logic        clk, rst_n, sclk, csN, sdi, sdo, rxValid;
  logic [23:0] refCapturePos;
  logic [7:0]  rxByte;
  logic [6:0]  ctl0;
  logic [3:0]  ctl1;
  logic [31:0] rng;
  logic [7:0]  wd [4];
  logic [7:0]  expQ [$];
  int          miscompares, samples_checked;

  spi_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi),
    .sdo(sdo), .rxByte(rxByte), .rxValid(rxValid));
  id_and_sync_clock_config_regs #(.DEVICE_CLASS(CLS), .FAMILY_CODE(FAM),
    .MAKER_CODE(MKR)) DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .csN(csN), .sdi(sdi), .sdo(sdo), .refCapturePos(refCapturePos),
    .refReceiverEnable(ctl0[5]), .refProcessorEnable(ctl0[6]),
    .refFineWindow(ctl0[4]), .refDelaySelect(ctl0[3:0]),
    .refTimestampEnable(ctl1[3]), .devClkLvpeclEnable(ctl1[2]),
    .refLvpeclEnable(ctl1[1]), .refInvert(ctl1[0]));

  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Notes the expected bytes, then runs the read frame.
  task automatic rd(input logic [14:0] a, input logic [23:0] e, input int n);
    for (int k = 0; k < n; k++)
      expQ.push_back(e[8*k +: 8]);
    host.frame(1'b1, a, n, wd);
  endtask

  task automatic summarize();
    // Expected bytes that never came back count as mismatches.
    miscompares += expQ.size();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compares each read byte with the oldest expected value.
  always @(posedge clk) begin
    logic [7:0] e;
    if (rxValid === 1'b1) begin
      e = expQ.size() ? expQ.pop_front() : 8'hxx;
      check("read byte", rxByte, e);
    end
  end

  // Cuts a hang short; a clean run needs well under half of this span.
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    refCapturePos = 24'h000000;
    rng = 32'h0000000c;
    wd = '{8'hff, 8'hff, 8'hff, 8'hff};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check("ctl0 reset", {1'b0, ctl0}, 8'h00);
    check("ctl1 reset", {4'h0, ctl1}, 8'h00);
    // Give the port a little time after release before the first frame.
    repeat (2) @(negedge clk);
    rd(15'h0000, 24'h000030, 1);
    rd(15'h0003, {16'h0000, 4'h0, CLS}, 1);
    host.frame(1'b0, 15'h0003, 3, wd);
    rd(15'h0003, {FAM, 4'hf, CLS}, 3);
    host.frame(1'b0, 15'h000c, 2, wd);
    rd(15'h000c, {8'h00, MKR}, 2);
    rd(15'h0100, 24'h000000, 1);
    $display("identification test done");
    // Receiver before processor, delay select last left at zero.
    for (int i = 0; i < 16; i++) begin
      rng = nextRand(rng);
      host.halfCyc = i[0] ? 3 : 6;
      wd[0] = {rng[7], i > 1, i > 0, rng[4], 4'(15 - i)};
      host.frame(1'b0, 15'h0029, 1, wd);
      check("ctl0", {1'b0, ctl0}, {1'b0, wd[0][6:0]});
      rd(15'h0029, {16'h0000, wd[0]}, 1);
    end
    $display("control test done");
    wd[0] = 8'h00;
    host.frame(1'b0, 15'h0000, 1, wd);
    rd(15'h0000, 24'h000010, 1);
    wd[0] = 8'ha5;
    wd[1] = 8'h2c;
    host.frame(1'b0, 15'h002a, 2, wd);
    check("ctl1 down", {4'h0, ctl1}, 8'h05);
    check("ctl0 down", {1'b0, ctl0}, 8'h2c);
    rd(15'h002a, 24'h002ca5, 2);
    $display("descend test done");
    wd[0] = 8'h21;
    host.frame(1'b0, 15'h0000, 1, wd);
    wd[0] = 8'h01;
    host.frame(1'b0, 15'h0010, 1, wd);
    wd[0] = 8'h3f;
    wd[1] = 8'h31;
    host.frame(1'b0, 15'h0029, 2, wd);
    check("ctl0 hold", {1'b0, ctl0}, 8'h31);
    check("ctl1 hold", {4'h0, ctl1}, 8'h05);
    rd(15'h0029, 24'h313131, 3);
    $display("hold test done");
    // Soft reset clears the controls and the address hold and restores the port configuration reset value.
    wd[0] = 8'h80;
    host.frame(1'b0, 15'h0000, 1, wd);
    check("ctl0 soft", {1'b0, ctl0}, 8'h00);
    check("ctl1 soft", {4'h0, ctl1}, 8'h00);
    rd(15'h0000, 24'h000030, 1);
    rd(15'h0010, 24'h000000, 1);
    $display("soft reset test done");
    // Position bytes stream upward now that the address hold is clear.
    rng = nextRand(rng);
    refCapturePos = rng[23:0];
    @(negedge clk);
    rd(15'h002c, rng[23:0], 3);
    $display("position test done");
    // A pin reset in mid-run clears controls that the host left set.
    wd[0] = 8'h20;
    wd[1] = 8'h0f;
    host.frame(1'b0, 15'h0029, 2, wd);
    check("ctl0 set", {1'b0, ctl0}, 8'h20);
    check("ctl1 set", {4'h0, ctl1}, 8'h0f);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check("ctl0 pin", {1'b0, ctl0}, 8'h00);
    check("ctl1 pin", {4'h0, ctl1}, 8'h00);
    repeat (2) @(negedge clk);
    rd(15'h0029, 24'h000000, 2);
    $display("pin reset test done");
    summarize();
  end
endmodule

bind id_and_sync_clock_config_regs id_regs_chk u_chk (.clk(clk),
  .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
  .refCapturePos(refCapturePos), .refReceiverEnable(refReceiverEnable),
  .refProcessorEnable(refProcessorEnable), .refFineWindow(refFineWindow),
  .refDelaySelect(refDelaySelect), .refTimestampEnable(refTimestampEnable),
  .devClkLvpeclEnable(devClkLvpeclEnable),
  .refLvpeclEnable(refLvpeclEnable), .refInvert(refInvert));
